/* pss_pid_model.sv */
`timescale 1ns/10ps
module pss_pid_model (
    input wire logic clk,
    input wire logic [1:0] want_loop,
    input wire logic [3:0] loop2_target_source,
    output logic loop_select_bit0,
    output logic loop_select_bit1,
    output logic [15:0] loop1_output
);
    import pss_pkg::*;
    logic [1:0] sel;
    // The terminals can only pick loop 2 while the cascade is on, so any other request is overridden.
    assign sel = (loop2_target_source == LOOP2_SRC_LOOP1_OUT) ? LOOP_TWO : want_loop;
    always_ff @(posedge clk)
    begin
        loop_select_bit0 <= sel[0];
        loop_select_bit1 <= sel[1];
        loop1_output <= 16'h1234;
    end
endmodule

/* pss_pkg.sv */
package pss_pkg;
    // Selection codes for the sleep and wake conditions and the boost enable.
    localparam logic [1:0] SLEEP_SEL_OFF = 2'h0;
    localparam logic [1:0] SLEEP_SEL_LOW_OUT = 2'h1;
    localparam logic [1:0] SLEEP_SEL_TERMINAL = 2'h2;
    localparam logic [1:0] WAKE_SEL_DEVIATION = 2'h1;
    localparam logic [1:0] WAKE_SEL_FB_LOW = 2'h2;
    localparam logic [1:0] WAKE_SEL_TERMINAL = 2'h3;
    localparam logic [1:0] BOOST_SEL_ON = 2'h1;
    // Input terminal function codes.
    localparam logic [7:0] TERM_FN_SLEEP_REQUEST = 8'h39;
    localparam logic [7:0] TERM_FN_RESUME_REQUEST = 8'h3A;
    // Target source code that cascades loop 1 output into loop 2.
    localparam logic [3:0] LOOP2_SRC_LOOP1_OUT = 4'hF;
    localparam logic [1:0] LOOP_TWO = 2'h1;
    // Levels are in 0.01 units: 590.00 Hz and 100.00 percent.
    localparam logic [15:0] FREQ_MAX = 16'hE678;
    localparam logic [15:0] PERCENT_MAX = 16'h2710;
    // All times are in 0.01 s steps, at most 100.00 s.
    localparam logic [15:0] TIME_MAX = 16'h2710;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_NS = 10000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int PRESC_W = 17;
    localparam int LOOPS = 4;
    localparam logic [15:0] TMR_SAT = 16'hFFFF;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_BOOST,
        ST_SLEEP
    } pss_state_type;

    typedef struct packed {
        pss_state_type state;
        logic [PRESC_W-1:0] presc;
        logic tick;
        logic [15:0] run_tmr;
        logic [15:0] qual_tmr;
        logic [15:0] hold_tmr;
        logic [15:0] boost_tmr;
        logic sleep_in_prev;
        logic wake_in_prev;
        logic sleep_pend;
        logic wake_pend;
        logic [LOOPS-1:0][16:0] dev;
        logic [1:0] active;
        logic [LOOPS-1:0] loop_en;
        logic conflict;
        logic sleep_o;
        logic boost_o;
        logic [15:0] target_o;
        logic [16:0] act_dev;
    } pss_regs_type;
endpackage

/* pss_sleep_wake.sv */
`timescale 1ns/10ps
// Function
// - Sleep select: off, low output, terminal edge.
// - Low output must persist for sleep delay.
// - Terminal sleep after delay from rising edge.
// - Terminals 057/058 act only when selected.
// - Wake select: deviation, feedback low, terminal.
// - Deviation above level for wake delay wakes.
// - Wake deviation ignores polarity invert setting.
// - Feedback below level for wake delay wakes.
// - Terminal wake after delay from rising edge.
// - Boost only when boost enable is one.
// - Boost adds amount to target for time.
// - No sleep before minimum run time.
// - Stay asleep at least the minimum hold.
// - Two select bits choose loop one..four.
// - Four loops keep independent state.
// - Cascade: loop 2 follows loop 1 output.
// - Deviation polarity set by invert bit.
module pss_sleep_wake #(
    parameter int TICK_CYCLES_P = pss_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run_active,
    input wire logic [15:0] output_freq,
    input wire logic [1:0] sleep_condition_select,
    input wire logic [15:0] sleep_start_level,
    input wire logic [15:0] sleep_delay_time,
    input wire logic [1:0] pre_sleep_boost_enable,
    input wire logic [15:0] pre_sleep_boost_time,
    input wire logic [15:0] pre_sleep_boost_amount,
    input wire logic [15:0] min_run_before_sleep,
    input wire logic [15:0] min_sleep_hold,
    input wire logic [1:0] wake_condition_select,
    input wire logic [15:0] wake_feedback_level,
    input wire logic [15:0] wake_delay_time,
    input wire logic [15:0] wake_deviation_level,
    input wire logic [7:0] sleep_input_function,
    input wire logic [7:0] resume_input_function,
    input wire logic sleep_request_input,
    input wire logic resume_request_input,
    input wire logic loop_select_bit0,
    input wire logic loop_select_bit1,
    input wire logic [3:0] loop2_target_source,
    input wire logic [pss_pkg::LOOPS-1:0] deviation_polarity_invert,
    input wire logic [pss_pkg::LOOPS-1:0][15:0] loop_target,
    input wire logic [pss_pkg::LOOPS-1:0][15:0] loop_feedback,
    input wire logic [15:0] loop1_output,
    output logic pid_sleep,
    output logic boost_active,
    output logic [15:0] boosted_target,
    output logic [16:0] active_deviation,
    output logic [1:0] active_loop,
    output logic [pss_pkg::LOOPS-1:0] loop_enable,
    output logic cascade_conflict,
    output logic [pss_pkg::LOOPS-1:0][16:0] loop_deviation
);
    import pss_pkg::*;

    pss_regs_type r;
    pss_regs_type n;

    // Saturating qualification timer; a dropped condition restarts it.
    function automatic logic [15:0] qual_next(input logic cond, input logic tick, input logic [15:0] cnt);
        logic [15:0] res;
        res = 16'h0000;
        if (cond)
        begin
            res = (tick && cnt != TMR_SAT) ? cnt + 16'h0001 : cnt;
        end
        return res;
    endfunction

    function automatic logic [16:0] dev_calc(input logic [15:0] tgt, input logic [15:0] fb, input logic inv);
        logic [16:0] res;
        res = inv ? ({1'b0, fb} - {1'b0, tgt}) : ({1'b0, tgt} - {1'b0, fb});
        return res;
    endfunction

    logic [LOOPS-1:0][15:0] eff_target;
    logic cascade;
    logic [1:0] sel_loop;
    logic sleep_term_ok;
    logic wake_term_ok;
    logic low_out;
    logic run_ok;
    logic wake_cond;
    logic [16:0] wake_dev;
    logic [16:0] boost_sum;

    always_comb
    begin
        n = r;
        cascade = (loop2_target_source == LOOP2_SRC_LOOP1_OUT);
        eff_target = loop_target;
        if (cascade)
        begin
            eff_target[1] = loop1_output;
        end
        for (int i = 0; i < LOOPS; i++)
        begin
            n.dev[i] = dev_calc(eff_target[i], loop_feedback[i], deviation_polarity_invert[i]);
        end
        sel_loop = {loop_select_bit1, loop_select_bit0};
        // A cascaded setup only allows loop 2, so any other choice is flagged and overridden.
        n.conflict = cascade && sel_loop != LOOP_TWO;
        n.active = cascade ? LOOP_TWO : sel_loop;
        n.loop_en = 4'h1 << n.active;
        n.act_dev = n.dev[n.active];

        n.presc = (r.presc == PRESC_W'(TICK_CYCLES_P - 1)) ? '0 : r.presc + 1'b1;
        n.tick = (r.presc == PRESC_W'(TICK_CYCLES_P - 1));

        sleep_term_ok = (sleep_input_function == TERM_FN_SLEEP_REQUEST)
                        && (sleep_condition_select == SLEEP_SEL_TERMINAL);
        wake_term_ok = (resume_input_function == TERM_FN_RESUME_REQUEST)
                       && (wake_condition_select == WAKE_SEL_TERMINAL);
        n.sleep_in_prev = sleep_request_input;
        n.wake_in_prev = resume_request_input;
        low_out = (sleep_condition_select == SLEEP_SEL_LOW_OUT) && (output_freq < sleep_start_level);
        run_ok = (r.run_tmr >= min_run_before_sleep);
        // Wake works on target minus feedback whatever the loop polarity is.
        wake_dev = dev_calc(eff_target[r.active], loop_feedback[r.active], 1'b0);
        wake_cond = 1'b0;
        case (wake_condition_select)
            WAKE_SEL_DEVIATION: wake_cond = !wake_dev[16] && wake_dev[15:0] > wake_deviation_level;
            WAKE_SEL_FB_LOW: wake_cond = loop_feedback[r.active] < wake_feedback_level;
            WAKE_SEL_TERMINAL: wake_cond = r.wake_pend;
            default: wake_cond = 1'b0;
        endcase
        boost_sum = {1'b0, eff_target[r.active]} + {1'b0, pre_sleep_boost_amount};

        case (r.state)
            ST_RUN:
            begin
                n.run_tmr = qual_next(1'b1, r.tick, r.run_tmr);
                n.hold_tmr = '0;
                n.boost_tmr = '0;
                n.wake_pend = 1'b0;
                // The clear that leaving this state performs wins over this set.
                n.sleep_pend = (sleep_term_ok && sleep_request_input && !r.sleep_in_prev) || r.sleep_pend;
                case (sleep_condition_select)
                    SLEEP_SEL_LOW_OUT: n.qual_tmr = qual_next(low_out, r.tick, r.qual_tmr);
                    SLEEP_SEL_TERMINAL: n.qual_tmr = qual_next(r.sleep_pend, r.tick, r.qual_tmr);
                    default:
                    begin
                        n.qual_tmr = '0;
                        n.sleep_pend = 1'b0;
                    end
                endcase
                if (sleep_condition_select != SLEEP_SEL_OFF && run_ok && r.qual_tmr >= sleep_delay_time
                    && (low_out || r.sleep_pend))
                begin
                    n.state = (pre_sleep_boost_enable == BOOST_SEL_ON && low_out) ? ST_BOOST : ST_SLEEP;
                    n.qual_tmr = '0;
                    n.sleep_pend = 1'b0;
                end
            end
            ST_BOOST:
            begin
                n.boost_tmr = qual_next(1'b1, r.tick, r.boost_tmr);
                if (r.boost_tmr >= pre_sleep_boost_time)
                begin
                    n.state = ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                n.hold_tmr = qual_next(1'b1, r.tick, r.hold_tmr);
                n.wake_pend = (wake_term_ok && resume_request_input && !r.wake_in_prev) || r.wake_pend;
                n.qual_tmr = qual_next(wake_cond, r.tick, r.qual_tmr);
                // The hold time keeps a noisy wake condition from toggling the pump.
                if (wake_cond && r.qual_tmr >= wake_delay_time && r.hold_tmr >= min_sleep_hold)
                begin
                    n.state = ST_RUN;
                    n.qual_tmr = '0;
                    n.wake_pend = 1'b0;
                    n.run_tmr = '0;
                end
            end
            default: n.state = ST_RUN;
        endcase
        if (!run_active)
        begin
            n.state = ST_RUN;
            n.run_tmr = '0;
            n.qual_tmr = '0;
            n.sleep_pend = 1'b0;
            n.wake_pend = 1'b0;
        end
        n.sleep_o = (n.state == ST_SLEEP);
        n.boost_o = (n.state == ST_BOOST);
        n.target_o = eff_target[n.active];
        if (n.state == ST_BOOST)
        begin
            n.target_o = (boost_sum > {1'b0, PERCENT_MAX}) ? PERCENT_MAX : boost_sum[15:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign pid_sleep = r.sleep_o;
    assign boost_active = r.boost_o;
    assign boosted_target = r.target_o;
    assign active_deviation = r.act_dev;
    assign active_loop = r.active;
    assign loop_enable = r.loop_en;
    assign cascade_conflict = r.conflict;
    assign loop_deviation = r.dev;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_sleep_disabled: assert property ((sleep_condition_select == SLEEP_SEL_OFF && r.state == ST_RUN)
        |=> r.state == ST_RUN) else $error("Sleep entered while disabled.");
    a_sleep_low_qual: assert property ((r.state == ST_RUN && n.state != ST_RUN
        && sleep_condition_select == SLEEP_SEL_LOW_OUT) |-> r.qual_tmr >= sleep_delay_time
        && output_freq < sleep_start_level) else $error("Low output sleep not qualified.");
    a_min_run_time: assert property ((r.state == ST_RUN && n.state != ST_RUN)
        |-> r.run_tmr >= min_run_before_sleep) else $error("Sleep before minimum run time.");
    a_sleep_hold: assert property ((r.state == ST_SLEEP && n.state == ST_RUN && run_active)
        |-> r.hold_tmr >= min_sleep_hold && r.qual_tmr >= wake_delay_time)
        else $error("Wake before hold or delay elapsed.");
    a_wake_restart: assert property ((r.state == ST_SLEEP && run_active && !wake_cond)
        |=> r.qual_tmr == 16'h0000) else $error("Wake timer not restarted.");
    a_boost_gate: assert property ((pre_sleep_boost_enable != BOOST_SEL_ON && r.state == ST_RUN)
        |=> r.state != ST_BOOST) else $error("Boost while disabled.");
    a_boost_cap: assert property (r.boost_o |-> r.target_o <= PERCENT_MAX && r.state == ST_BOOST)
        else $error("Boost target out of range.");
    a_loop_select: assert property (!cascade |=> r.active == $past(sel_loop)
        && r.loop_en == (4'h1 << $past(sel_loop))) else $error("Wrong loop selected.");
    a_cascade_loop: assert property (cascade |=> r.active == LOOP_TWO
        && r.conflict == ($past(sel_loop) != LOOP_TWO)) else $error("Cascade loop not forced.");

    // The qual, boost entry and boost time checks guard the ways out of a state, so a wrong qualifier shows at the cycle it acts.
    a_term_sleep_qual: assert property (
        (r.state == ST_RUN && n.state != ST_RUN && sleep_condition_select == SLEEP_SEL_TERMINAL)
        |-> r.sleep_pend && r.qual_tmr >= sleep_delay_time)
        else $error("Terminal sleep not qualified.");

    a_sleep_func_gate: assert property (
        (r.state == ST_RUN && !r.sleep_pend && !sleep_term_ok)
        |=> !r.sleep_pend)
        else $error("Sleep edge taken while terminal not selected.");

    a_wake_func_gate: assert property (
        (r.state == ST_SLEEP && !r.wake_pend && !wake_term_ok && run_active)
        |=> !r.wake_pend)
        else $error("Wake edge taken while terminal not selected.");

    a_wake_dev_qual: assert property (
        (r.state == ST_SLEEP && n.state == ST_RUN && run_active && wake_condition_select == WAKE_SEL_DEVIATION)
        |-> !wake_dev[16] && wake_dev[15:0] > wake_deviation_level)
        else $error("Deviation wake not qualified.");

    a_wake_fb_qual: assert property (
        (r.state == ST_SLEEP && n.state == ST_RUN && run_active && wake_condition_select == WAKE_SEL_FB_LOW)
        |-> loop_feedback[r.active] < wake_feedback_level)
        else $error("Feedback wake not qualified.");

    a_wake_term_qual: assert property (
        (r.state == ST_SLEEP && n.state == ST_RUN && run_active && wake_condition_select == WAKE_SEL_TERMINAL)
        |-> r.wake_pend)
        else $error("Terminal wake without edge.");

    a_boost_entry: assert property (
        (r.state == ST_RUN && n.state == ST_BOOST)
        |-> pre_sleep_boost_enable == BOOST_SEL_ON && low_out)
        else $error("Boost entered without low output.");

    a_boost_time: assert property (
        (r.state == ST_BOOST && n.state == ST_SLEEP)
        |-> r.boost_tmr >= pre_sleep_boost_time)
        else $error("Boost ended early.");

    a_low_restart: assert property (
        (r.state == ST_RUN && sleep_condition_select == SLEEP_SEL_LOW_OUT && !low_out)
        |=> r.qual_tmr == 16'h0000)
        else $error("Sleep timer not restarted.");

    a_stop_wakes: assert property (
        !run_active
        |=> r.state == ST_RUN && !r.sleep_o && r.run_tmr == 16'h0000)
        else $error("Stop did not force awake.");

    a_cascade_target: assert property (
        (cascade && n.state != ST_BOOST)
        |=> r.target_o == $past(loop1_output))
        else $error("Cascade target not taken.");

    a_dev_plain: assert property (
        !deviation_polarity_invert[0]
        |=> r.dev[0] == $past({1'b0, loop_target[0]} - {1'b0, loop_feedback[0]}))
        else $error("Loop deviation polarity wrong.");
endmodule

/* pss_sleep_wake_tb.sv */
`timescale 1ns/10ps
module pss_sleep_wake_tb;
    import pss_pkg::*;
    localparam int TK = 4;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic run_active = 1'b0;
    logic sleep_request_input = 1'b0;
    logic resume_request_input = 1'b0;
    logic [15:0] output_freq = 16'h1388;
    logic [15:0] sleep_start_level = 16'h03E8;
    logic [15:0] sleep_delay_time = 16'h0003;
    logic [15:0] pre_sleep_boost_time = 16'h0003;
    logic [15:0] pre_sleep_boost_amount = 16'h0064;
    logic [15:0] min_run_before_sleep = 16'h0000;
    logic [15:0] min_sleep_hold = 16'h0000;
    logic [15:0] wake_feedback_level = 16'h0100;
    logic [15:0] wake_delay_time = 16'h0002;
    logic [15:0] wake_deviation_level = 16'h0010;
    logic [1:0] sleep_condition_select = 2'h0;
    logic [1:0] pre_sleep_boost_enable = 2'h0;
    logic [1:0] wake_condition_select = 2'h0;
    logic [1:0] want = 2'h0;
    logic [7:0] sleep_input_function = TERM_FN_SLEEP_REQUEST;
    logic [7:0] resume_input_function = TERM_FN_RESUME_REQUEST;
    logic [3:0] loop2_target_source = 4'h0;
    logic [3:0] deviation_polarity_invert = 4'h0;
    logic [3:0][15:0] loop_target = {4{16'h0100}};
    logic [3:0][15:0] loop_feedback = {4{16'h0200}};
    logic loop_select_bit0, loop_select_bit1, pid_sleep, boost_active, cascade_conflict;
    logic [15:0] loop1_output, boosted_target;
    logic [16:0] active_deviation;
    logic [1:0] active_loop;
    logic [3:0] loop_enable;
    logic [3:0][16:0] loop_deviation;
    int bad_count = 0;
    int tests_run = 0;
    pss_sleep_wake #(.TICK_CYCLES_P(TK)) uut (.clk, .reset_n, .run_active, .output_freq, .sleep_condition_select,
        .sleep_start_level, .sleep_delay_time, .pre_sleep_boost_enable, .pre_sleep_boost_time, .pre_sleep_boost_amount,
        .min_run_before_sleep, .min_sleep_hold, .wake_condition_select, .wake_feedback_level, .wake_delay_time,
        .wake_deviation_level, .sleep_input_function, .resume_input_function, .sleep_request_input,
        .resume_request_input, .loop_select_bit0, .loop_select_bit1, .loop2_target_source, .deviation_polarity_invert,
        .loop_target, .loop_feedback, .loop1_output, .pid_sleep, .boost_active, .boosted_target, .active_deviation,
        .active_loop, .loop_enable, .cascade_conflict, .loop_deviation);
    pss_pid_model pid (.clk, .want_loop(want), .loop2_target_source, .loop_select_bit0, .loop_select_bit1,
        .loop1_output);
    always #50 clk = ~clk;
    task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Timers step on a tick whose phase is unknown here, so checks bracket the moment from both sides.
    task automatic win(input int e, input int l, input logic v);
        cyc(e);
        chk("pid_sleep early", !v, pid_sleep);
        cyc(l - e);
        chk("pid_sleep late", v, pid_sleep);
    endtask
    task automatic wait_sl(input logic v);
        int k = 0;
        while (pid_sleep !== v && k < 200)
        begin
            cyc(1);
            k++;
        end
        chk("pid_sleep wait", v, pid_sleep);
    endtask
    task automatic restart();
        @(posedge clk);
        run_active <= 1'b0;
        cyc(2);
        @(posedge clk);
        run_active <= 1'b1;
    endtask
    task automatic pulse(input logic w);
        @(posedge clk);
        sleep_request_input <= !w;
        resume_request_input <= w;
        @(posedge clk);
        sleep_request_input <= 1'b0;
        resume_request_input <= 1'b0;
    endtask
    task automatic t_loops();
        logic [16:0] d;
        @(posedge clk);
        deviation_polarity_invert <= 4'h5;
        loop_feedback <= {16'h0080, 16'h0081, 16'h0082, 16'h0083};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            want <= 2'(i);
            cyc(4);
            chk("active_loop", 17'(i), active_loop);
            chk("loop_enable", 17'h00001 << i, loop_enable);
        end
        chk("active_deviation", 17'h00080, active_deviation);
        for (int j = 0; j < 4; j++)
        begin
            d = 17'h0007D + 17'(j);
            chk("loop_deviation", (j % 2) ? d : -d, loop_deviation[j]);
        end
        @(posedge clk);
        loop_feedback <= {4{16'h0200}};
        want <= 2'h0;
        $display("t_loops done");
    endtask
    task automatic t_cascade();
        @(posedge clk);
        loop2_target_source <= LOOP2_SRC_LOOP1_OUT;
        want <= 2'h3;
        cyc(4);
        chk("active_loop", 17'(LOOP_TWO), active_loop);
        chk("boosted_target", 17'h01234, boosted_target);
        chk("cascade_conflict", 17'h00000, cascade_conflict);
        @(posedge clk);
        loop2_target_source <= 4'h0;
        want <= 2'h0;
        $display("t_cascade done");
    endtask
    task automatic t_low();
        @(posedge clk);
        output_freq <= 16'h0064;
        restart();
        cyc(6 * TK);
        chk("pid_sleep off", 17'h00000, pid_sleep);
        @(posedge clk);
        sleep_condition_select <= SLEEP_SEL_LOW_OUT;
        cyc(2 * TK);
        @(posedge clk);
        output_freq <= 16'h1388;
        @(posedge clk);
        output_freq <= 16'h0064;
        win(2 * TK, 5 * TK, 1'b1);
        chk("boost_active", 17'h00000, boost_active);
        @(posedge clk);
        min_run_before_sleep <= 16'h0006;
        sleep_delay_time <= 16'h0001;
        restart();
        win(4 * TK, 8 * TK, 1'b1);
        @(posedge clk);
        min_run_before_sleep <= 16'h0000;
        $display("t_low done");
    endtask
    task automatic t_boost();
        @(posedge clk);
        pre_sleep_boost_enable <= BOOST_SEL_ON;
        restart();
        cyc(3 * TK);
        chk("boost_active", 17'h00001, boost_active);
        chk("boosted_target", 17'h00164, boosted_target);
        chk("pid_sleep", 17'h00000, pid_sleep);
        cyc(3 * TK);
        chk("pid_sleep", 17'h00001, pid_sleep);
        chk("boost_active", 17'h00000, boost_active);
        @(posedge clk);
        pre_sleep_boost_enable <= 2'h0;
        $display("t_boost done");
    endtask
    task automatic t_fbwake();
        @(posedge clk);
        min_sleep_hold <= 16'h0006;
        wake_condition_select <= WAKE_SEL_FB_LOW;
        restart();
        wait_sl(1'b1);
        @(posedge clk);
        loop_feedback[0] <= 16'h0080;
        output_freq <= 16'h1388;
        win(3 * TK, 8 * TK, 1'b0);
        @(posedge clk);
        min_sleep_hold <= 16'h0000;
        loop_feedback[0] <= 16'h0200;
        output_freq <= 16'h0064;
        $display("t_fbwake done");
    endtask
    task automatic t_devwake();
        @(posedge clk);
        wake_condition_select <= WAKE_SEL_DEVIATION;
        restart();
        wait_sl(1'b1);
        cyc(5 * TK);
        chk("pid_sleep", 17'h00001, pid_sleep);
        @(posedge clk);
        loop_feedback[0] <= 16'h0080;
        output_freq <= 16'h1388;
        win(TK, 5 * TK, 1'b0);
        $display("t_devwake done");
    endtask
    task automatic t_term();
        @(posedge clk);
        sleep_condition_select <= SLEEP_SEL_TERMINAL;
        wake_condition_select <= WAKE_SEL_TERMINAL;
        sleep_delay_time <= 16'h0002;
        sleep_input_function <= 8'h3B;
        restart();
        pulse(1'b0);
        cyc(5 * TK);
        chk("pid_sleep", 17'h00000, pid_sleep);
        @(posedge clk);
        sleep_input_function <= TERM_FN_SLEEP_REQUEST;
        pulse(1'b0);
        win(TK, 4 * TK, 1'b1);
        pulse(1'b1);
        win(TK, 4 * TK, 1'b0);
        $display("t_term done");
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        run_active <= 1'b1;
        t_loops();
        t_cascade();
        t_low();
        t_boost();
        t_fbwake();
        t_devwake();
        t_term();
        results();
    end
    // The tests need well under a thousand cycles; five thousand leaves room without hiding a hang.
    initial
    begin
        #(5000 * 100);
        bad_count++;
        results();
    end
endmodule
